// ==== common/spiirl_pkg.sv ====
// Purpose: Shared constants and types for the serial peripheral block.
// Assumes: 8-bit frames, leading-edge drive and trailing-edge sample.
// Notes: Bit positions refer to the control and configuration write words.
`default_nettype none
package spiirl_pkg;
	// Frame length
	localparam int DATA_BITS = 8;
	// Control word bit positions
	localparam int CTL_TX_IE = 0;
	localparam int CTL_RX_IE = 1;
	localparam int CTL_MASTER = 2;
	localparam int CTL_WIRED_OR = 3;
	localparam int CTL_ENABLE = 4;
	localparam int CTL_WIDTH = 5;
	// Master select is set by reset, everything else clear
	localparam logic [CTL_WIDTH-1:0] CTL_RESET = 5'h04;
	// Configuration word bit positions
	localparam int CFG_RATE_LO = 0;
	localparam int CFG_RATE_HI = 1;
	localparam int CFG_ERR_IE = 2;
	localparam int CFG_MODE_FAULT_FLAG_EN = 3;
	localparam int CFG_WIDTH = 4;
	localparam logic [CFG_WIDTH-1:0] CFG_RESET = 4'h0;
	// Half bit times in system cycles for divide by 2, 8, 32, 128
	localparam logic [6:0] HALF_DIV2 = 7'h01;
	localparam logic [6:0] HALF_DIV8 = 7'h04;
	localparam logic [6:0] HALF_DIV32 = 7'h10;
	localparam logic [6:0] HALF_DIV128 = 7'h40;
	// Last bit index of a frame
	localparam logic [2:0] LAST_BIT = 3'h7;
	// Master shift engine states
	typedef enum logic [2:0] {
		SPIIRL_M_IDLE = 3'b001,
		SPIIRL_M_LOW = 3'b010,
		SPIIRL_M_HIGH = 3'b100
	} spiirl_mst_type;
endpackage : spiirl_pkg
`default_nettype wire

// ==== logic/spiirl_core.sv ====
// Purpose: Serial peripheral master/slave with flags, queuing, partial reset and break protection.
// Assumes: Slave serial clock is a separate domain that only runs inside frames.
// Notes: Only the leading-edge-drive, trailing-edge-sample format with idle-low clock is built.
`timescale 1ns/100ps
`default_nettype none
module spiirl_core
	import spiirl_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic SERIAL_CLOCK_IN,
	input wire logic SLAVE_SELECT_N,
	input wire logic MOSI_IN,
	input wire logic MISO_IN,
	output logic SERIAL_CLOCK_OUT,
	output logic SERIAL_CLOCK_OE,
	output logic MOSI_OUT,
	output logic MOSI_OE,
	output logic MISO_OUT,
	output logic MISO_OE,
	input wire logic CONTROL_WRITE,
	input wire logic [CTL_WIDTH-1:0] CONTROL_WDATA,
	input wire logic CONFIG_WRITE,
	input wire logic [CFG_WIDTH-1:0] CONFIG_WDATA,
	input wire logic STATUS_READ,
	input wire logic DATA_WRITE,
	input wire logic [DATA_BITS-1:0] DATA_WDATA,
	input wire logic DATA_READ,
	input wire logic BREAK_ACTIVE,
	input wire logic BREAK_CLEAR_ENABLE,
	input wire logic WAIT_MODE,
	input wire logic STOP_MODE,
	output logic [DATA_BITS-1:0] RX_DATA,
	output logic [CTL_WIDTH-1:0] CONTROL_STATE,
	output logic [CFG_WIDTH-1:0] CONFIG_STATE,
	output logic TX_EMPTY,
	output logic RX_FULL,
	output logic OVERFLOW,
	output logic MODE_FAULT,
	output logic TX_IRQ,
	output logic RX_ERR_IRQ,
	output logic WAKE_REQ,
	output logic PORT_ACTIVE
);
	// Register state
	logic [CTL_WIDTH-1:0] ctl_reg, ctl_next;
	logic [CFG_WIDTH-1:0] cfg_reg;
	logic [DATA_BITS-1:0] tx_buf_reg, tx_slot_reg, tx_slot_next, rx_data_reg;
	logic tx_full_reg, tx_full_next, tx_empty_reg, tx_empty_next;
	logic rx_full_reg, rx_full_next, ovf_reg, ovf_next, mode_fault_flag_reg, mode_fault_flag_next;
	logic rx_arm_reg, rx_arm_next, ovf_arm_reg, ovf_arm_next, mode_fault_flag_arm_reg, mode_fault_flag_arm_next;
	logic tx_irq_reg, rx_irq_reg, wake_reg, slave_run_reg, miso_oe_reg;
	// Synchronisers from pins and the link domain
	logic ss_s1_reg, ss_s2_reg, miso_s1_reg, miso_s2_reg;
	logic tog_s1_reg, tog_s2_reg, tog_s3_reg, busy_s1_reg, busy_s2_reg;
	// Master engine
	spiirl_mst_type mst_reg, mst_next;
	logic [DATA_BITS-1:0] msh_reg, msh_next;
	logic [2:0] mcnt_reg, mcnt_next;
	logic [6:0] tmr_reg, tmr_next, half;
	logic sck_reg, sck_next, mosi_reg, mosi_next, sck_oe_reg, mosi_oe_reg;
	// Link domain
	logic [2:0] lcnt_reg;
	logic [DATA_BITS-2:0] lhold_reg;
	logic [DATA_BITS-1:0] lrx_reg, lword_reg;
	logic lout_reg, ltog_reg, lbusy_reg;

	// Common qualifiers
	wire enable = ctl_reg[CTL_ENABLE];
	wire master = ctl_reg[CTL_MASTER];
	wire wom = ctl_reg[CTL_WIRED_OR];
	wire mode_fault_flag_en = cfg_reg[CFG_MODE_FAULT_FLAG_EN];
	wire err_ie = cfg_reg[CFG_ERR_IE];
	wire cpu_ok = ~WAIT_MODE;
	wire break_hold = BREAK_ACTIVE & ~BREAK_CLEAR_ENABLE;
	wire clr_ok = cpu_ok & ~break_hold;
	wire status_rd = STATUS_READ & clr_ok;
	wire data_rd = DATA_READ & clr_ok;
	wire ctl_wr = CONTROL_WRITE & cpu_ok;
	wire cfg_wr = CONFIG_WRITE & cpu_ok;
	wire wr_ok = DATA_WRITE & clr_ok;
	wire master_run = enable & master;
	wire mst_idle = (mst_reg == SPIIRL_M_IDLE);
	wire tmr_zero = (tmr_reg == 7'h00);
	wire mst_done = (mst_reg == SPIIRL_M_HIGH) & tmr_zero & (mcnt_reg == LAST_BIT) & ~STOP_MODE;
	wire [DATA_BITS-1:0] mst_word = {msh_reg[DATA_BITS-2:0], miso_s2_reg};
	// queued byte loads once the engine is free
	wire mst_load = master_run & tx_full_reg & ~STOP_MODE & (mst_idle | mst_done);
	// slave buffer moves only between frames, a link frame reads it
	wire slv_load = slave_run_reg & ~master & tx_full_reg & ~busy_s2_reg;
	wire xfer_load = mst_load | slv_load;
	wire slv_done = tog_s2_reg ^ tog_s3_reg;
	wire rx_done = mst_done | (slv_done & slave_run_reg);
	wire [DATA_BITS-1:0] rx_word = mst_done ? mst_word : lword_reg;
	wire ovf_set = rx_done & rx_full_reg;
	wire rx_full_set = rx_done & ~rx_full_reg & ~ovf_reg;
	// fault detection gated by its enable
	wire fault_mst = master_run & mode_fault_flag_en & ~ss_s2_reg;
	wire fault_slv = enable & ~master & mode_fault_flag_en & ss_s2_reg & busy_s2_reg;
	wire fault_cond = fault_mst | fault_slv;
	wire link_clr = RESET | ~slave_run_reg;

	// Half bit time from the rate selects
	always_comb begin
		case (cfg_reg[CFG_RATE_HI:CFG_RATE_LO])
			2'h0: half = HALF_DIV2;
			2'h1: half = HALF_DIV8;
			2'h2: half = HALF_DIV32;
			default: half = HALF_DIV128;
		endcase
	end

	// Control word; a master fault wins over a software write
	always_comb begin
		ctl_next = ctl_reg;
		if (ctl_wr) begin
			ctl_next = CONTROL_WDATA;
		end
		if (fault_mst) begin
			ctl_next[CTL_ENABLE] = 1'b0;
		end
	end

	// Transmit buffering; sets beat clears
	always_comb begin
		tx_full_next = (wr_ok | (tx_full_reg & ~xfer_load)) & enable;
		tx_empty_next = ~enable | xfer_load | (tx_empty_reg & ~wr_ok);
		tx_slot_next = tx_slot_reg;
		if (slv_load) begin
			tx_slot_next = tx_buf_reg;
		end else if (slv_done & ~tx_full_reg) begin
			// resend what the shifter last held
			tx_slot_next = lword_reg;
		end
	end

	// Receive, overflow and fault flags with their two-step clears
	always_comb begin
		rx_full_next = rx_full_set | (rx_full_reg & ~(data_rd & rx_arm_reg));
		ovf_next = ovf_set | (ovf_reg & ~(data_rd & ovf_arm_reg));
		// clear only when no fault through the sequence
		mode_fault_flag_next = fault_cond | (mode_fault_flag_reg & ~(ctl_wr & mode_fault_flag_arm_reg & clr_ok));
		// arms survive a protected break untouched
		rx_arm_next = rx_arm_reg;
		ovf_arm_next = ovf_arm_reg;
		mode_fault_flag_arm_next = mode_fault_flag_arm_reg & ~fault_cond;
		if (status_rd) begin
			rx_arm_next = rx_full_reg;
			ovf_arm_next = ovf_reg;
			mode_fault_flag_arm_next = mode_fault_flag_reg & ~fault_cond;
		end else if (data_rd) begin
			rx_arm_next = 1'b0;
			ovf_arm_next = 1'b0;
		end
		if (ctl_wr & clr_ok) begin
			mode_fault_flag_arm_next = 1'b0;
		end
	end

	// Master shift engine; stop mode freezes every step
	always_comb begin
		mst_next = mst_reg;
		msh_next = msh_reg;
		mcnt_next = mcnt_reg;
		tmr_next = tmr_reg;
		sck_next = sck_reg;
		mosi_next = mosi_reg;
		case (mst_reg)
			SPIIRL_M_IDLE: begin
				sck_next = 1'b0;
			end
			SPIIRL_M_LOW: begin
				if (!STOP_MODE) begin
					tmr_next = tmr_reg - 7'h01;
					if (tmr_zero) begin
						sck_next = 1'b1;
						mosi_next = msh_reg[DATA_BITS-1];
						tmr_next = half - 7'h01;
						mst_next = SPIIRL_M_HIGH;
					end
				end
			end
			SPIIRL_M_HIGH: begin
				if (!STOP_MODE) begin
					tmr_next = tmr_reg - 7'h01;
					if (tmr_zero) begin
						sck_next = 1'b0;
						msh_next = mst_word;
						mcnt_next = mcnt_reg + 3'h1;
						tmr_next = half - 7'h01;
						mst_next = (mcnt_reg == LAST_BIT) ? SPIIRL_M_IDLE : SPIIRL_M_LOW;
					end
				end
			end
			default: begin
				mst_next = SPIIRL_M_IDLE;
			end
		endcase
		if (mst_load) begin
			msh_next = tx_buf_reg;
			mcnt_next = 3'h0;
			tmr_next = half - 7'h01;
			mst_next = SPIIRL_M_LOW;
		end
		// disable aborts and clears the shifter
		if (!master_run) begin
			mst_next = SPIIRL_M_IDLE;
			msh_next = {DATA_BITS{1'b0}};
			mcnt_next = 3'h0;
			sck_next = 1'b0;
			mosi_next = 1'b0;
		end
	end

	// system reset for all CPU-visible state
	// flags and control bits only touch reset here
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			ctl_reg <= CTL_RESET;
			cfg_reg <= CFG_RESET;
			tx_buf_reg <= {DATA_BITS{1'b0}};
			tx_slot_reg <= {DATA_BITS{1'b0}};
			rx_data_reg <= {DATA_BITS{1'b0}};
			tx_full_reg <= 1'b0;
			tx_empty_reg <= 1'b1;
			rx_full_reg <= 1'b0;
			ovf_reg <= 1'b0;
			mode_fault_flag_reg <= 1'b0;
			rx_arm_reg <= 1'b0;
			ovf_arm_reg <= 1'b0;
			mode_fault_flag_arm_reg <= 1'b0;
		end else begin
			ctl_reg <= ctl_next;
			cfg_reg <= cfg_wr ? CONFIG_WDATA : cfg_reg;
			tx_buf_reg <= wr_ok ? DATA_WDATA : tx_buf_reg;
			tx_slot_reg <= tx_slot_next;
			rx_data_reg <= rx_full_set ? rx_word : rx_data_reg;
			tx_full_reg <= tx_full_next;
			tx_empty_reg <= tx_empty_next;
			rx_full_reg <= rx_full_next;
			ovf_reg <= ovf_next;
			mode_fault_flag_reg <= mode_fault_flag_next;
			rx_arm_reg <= rx_arm_next;
			ovf_arm_reg <= ovf_arm_next;
			mode_fault_flag_arm_reg <= mode_fault_flag_arm_next;
		end
	end

	// Master engine and pin drivers; open-drain only drives low
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			mst_reg <= SPIIRL_M_IDLE;
			msh_reg <= {DATA_BITS{1'b0}};
			mcnt_reg <= 3'h0;
			tmr_reg <= 7'h00;
			sck_reg <= 1'b0;
			mosi_reg <= 1'b0;
			sck_oe_reg <= 1'b0;
			mosi_oe_reg <= 1'b0;
		end else begin
			mst_reg <= mst_next;
			msh_reg <= msh_next;
			mcnt_reg <= mcnt_next;
			tmr_reg <= tmr_next;
			sck_reg <= sck_next;
			mosi_reg <= mosi_next;
			sck_oe_reg <= master_run & (~wom | ~sck_next);
			mosi_oe_reg <= master_run & (~wom | ~mosi_next);
		end
	end

	// Interrupt levels and pin ownership
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			tx_irq_reg <= 1'b0;
			rx_irq_reg <= 1'b0;
			wake_reg <= 1'b0;
			slave_run_reg <= 1'b0;
			miso_oe_reg <= 1'b0;
		end else begin
			// held while flag and enable stay
			tx_irq_reg <= tx_empty_next & ctl_next[CTL_TX_IE];
			// receive full gated by module enable
			// both error flags share one enable
			rx_irq_reg <= (rx_full_next & ctl_next[CTL_RX_IE] & ctl_next[CTL_ENABLE]) | (cfg_reg[CFG_ERR_IE] & (ovf_next | mode_fault_flag_next));
			// any enabled request wakes the processor
			wake_reg <= WAIT_MODE & ((tx_empty_next & ctl_next[CTL_TX_IE]) | (rx_full_next & ctl_next[CTL_RX_IE] & ctl_next[CTL_ENABLE]) | (err_ie & (ovf_next | mode_fault_flag_next)));
			slave_run_reg <= ctl_next[CTL_ENABLE] & ~ctl_next[CTL_MASTER];
			miso_oe_reg <= ctl_next[CTL_ENABLE] & ~ctl_next[CTL_MASTER] & ~ss_s2_reg;
		end
	end

	// Two-stage synchronisers, three stages for the toggle; the second stage and tog_s3_reg feed logic
	always_ff @(posedge CLK_SYS or posedge RESET) begin
		if (RESET) begin
			ss_s1_reg <= 1'b1;
			ss_s2_reg <= 1'b1;
			miso_s1_reg <= 1'b0;
			miso_s2_reg <= 1'b0;
			tog_s1_reg <= 1'b0;
			tog_s2_reg <= 1'b0;
			tog_s3_reg <= 1'b0;
			busy_s1_reg <= 1'b0;
			busy_s2_reg <= 1'b0;
		end else begin
			ss_s1_reg <= SLAVE_SELECT_N;
			ss_s2_reg <= ss_s1_reg;
			miso_s1_reg <= MISO_IN;
			miso_s2_reg <= miso_s1_reg;
			tog_s1_reg <= ltog_reg;
			tog_s2_reg <= tog_s1_reg;
			tog_s3_reg <= tog_s2_reg;
			busy_s1_reg <= lbusy_reg;
			busy_s2_reg <= busy_s1_reg;
		end
	end

	// Link leading edge drives MISO; the slot only changes while the link is idle
	// deselected slave ignores edges
	always_ff @(posedge SERIAL_CLOCK_IN or posedge link_clr) begin
		if (link_clr) begin
			lout_reg <= 1'b0;
			lhold_reg <= {(DATA_BITS-1){1'b0}};
		end else if (!SLAVE_SELECT_N) begin
			lout_reg <= (lcnt_reg == 3'h0) ? tx_slot_reg[DATA_BITS-1] : lhold_reg[DATA_BITS-2];
			lhold_reg <= (lcnt_reg == 3'h0) ? tx_slot_reg[DATA_BITS-2:0] : {lhold_reg[DATA_BITS-3:0], 1'b0};
		end
	end

	// Link trailing edge samples MOSI; word held for the next eight edges
	// disabling clears counter and shifter
	always_ff @(negedge SERIAL_CLOCK_IN or posedge link_clr) begin
		if (link_clr) begin
			lcnt_reg <= 3'h0;
			lrx_reg <= {DATA_BITS{1'b0}};
			lbusy_reg <= 1'b0;
		end else if (!SLAVE_SELECT_N) begin
			lrx_reg <= {lrx_reg[DATA_BITS-2:0], MOSI_IN};
			lcnt_reg <= lcnt_reg + 3'h1;
			lbusy_reg <= (lcnt_reg != LAST_BIT);
		end
	end

	// Completed word and its toggle survive a disable for the CPU side
	always_ff @(negedge SERIAL_CLOCK_IN or posedge RESET) begin
		if (RESET) begin
			lword_reg <= {DATA_BITS{1'b0}};
			ltog_reg <= 1'b0;
		end else if (!SLAVE_SELECT_N && slave_run_reg && lcnt_reg == LAST_BIT) begin
			lword_reg <= {lrx_reg[DATA_BITS-2:0], MOSI_IN};
			ltog_reg <= ~ltog_reg;
		end
	end

	// Outputs
	assign SERIAL_CLOCK_OUT = sck_reg;
	assign SERIAL_CLOCK_OE = sck_oe_reg;
	assign MOSI_OUT = mosi_reg;
	assign MOSI_OE = mosi_oe_reg;
	assign MISO_OUT = lout_reg;
	assign MISO_OE = miso_oe_reg;
	assign RX_DATA = rx_data_reg;
	assign CONTROL_STATE = ctl_reg;
	assign CONFIG_STATE = cfg_reg;
	assign TX_EMPTY = tx_empty_reg;
	assign RX_FULL = rx_full_reg;
	assign OVERFLOW = ovf_reg;
	assign MODE_FAULT = mode_fault_flag_reg;
	assign TX_IRQ = tx_irq_reg;
	assign RX_ERR_IRQ = rx_irq_reg;
	assign WAKE_REQ = wake_reg;
	assign PORT_ACTIVE = enable;

	// Checks on the system clock
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	tx_irq_level_a: assert property (tx_empty_reg && ctl_reg[CTL_TX_IE] && !wr_ok && !ctl_wr |=> TX_IRQ)
		else $error("transmit request missing");
	rx_irq_gate_a: assert property (!enable && !err_ie && !ctl_wr |=> !RX_ERR_IRQ)
		else $error("receive request without enable");
	err_irq_share_a: assert property (err_ie && ovf_reg && !cfg_wr && !data_rd |=> RX_ERR_IRQ)
		else $error("overflow request missing");
	mode_fault_flag_block_a: assert property (!mode_fault_flag_en && !mode_fault_flag_reg |=> !mode_fault_flag_reg)
		else $error("mode fault set while disabled");
	rx_full_set_a: assert property (rx_full_set |=> rx_full_reg && RX_DATA == $past(rx_word))
		else $error("receive byte not captured");
	tx_write_clear_a: assert property (wr_ok && !xfer_load && enable |=> !tx_empty_reg ##1 (tx_full_reg || tx_empty_reg))
		else $error("write did not clear tx empty");
	disable_abort_a: assert property (!enable && !ctl_wr |=> tx_empty_reg && mst_reg == SPIIRL_M_IDLE && !sck_oe_reg)
		else $error("disabled module still active");
	fault_drop_a: assert property (fault_mst |=> !enable && mode_fault_flag_reg)
		else $error("master fault kept enable");
	break_write_a: assert property (break_hold && DATA_WRITE && !tx_full_reg |=> !tx_full_reg && $stable(tx_buf_reg))
		else $error("break write was taken");
	rx_clear_a: assert property (data_rd && rx_arm_reg && !rx_done |=> !rx_full_reg)
		else $error("receive full not cleared");
endmodule : spiirl_core
`default_nettype wire

// ==== tb/spiirl_far.sv ====
// Purpose: Far side of the link: a slave answering our master and a master clocking our slave.
// Assumes: Leading edge drives, trailing edge samples, 8-bit frames, idle-low clock.
// Notes: Slave answers 8'hC0 plus its byte count; its clock stands still between frames.
`timescale 1ns/100ps
`default_nettype none
module spiirl_far (
	input wire logic sck_m,
	input wire logic mosi_m,
	output logic miso_m,
	output logic sck_s,
	output logic ss_n,
	output logic mosi_s,
	input wire logic miso_s
);
	logic [2:0] bit_reg = 3'h0;
	logic [7:0] cnt_reg = 8'h00;
	logic [7:0] sh_reg = 8'h00;
	logic [7:0] mrx = 8'h00;
	logic [7:0] got_q[$];
	logic [7:0] tx_byte;
	assign tx_byte = 8'hC0 + cnt_reg;
	// Idle levels before any frame
	initial begin
		miso_m = 1'b0;
		sck_s = 1'b0;
		ss_n = 1'b1;
		mosi_s = 1'b0;
	end
	// Slave drives its next bit on the rising clock
	always @(posedge sck_m) begin
		miso_m <= tx_byte[3'h7 - bit_reg];
	end
	// Slave samples on falling clock; between bytes the line shows the inverse of its last bit
	always @(negedge sck_m) begin
		sh_reg <= {sh_reg[6:0], mosi_m};
		bit_reg <= bit_reg + 3'h1;
		if (bit_reg == 3'h7) begin
			got_q.push_back({sh_reg[6:0], mosi_m});
			cnt_reg <= cnt_reg + 8'h01;
			miso_m <= ~miso_m;
		end
	end
	// Master clocks nb bits with select held at ssv; clock only runs inside the frame
	task automatic frame(input logic [7:0] b, input int nb, input logic ssv);
		ss_n = ssv;
		#45;
		for (int i = 0; i < nb; i++) begin
			mosi_s = b[7-i];
			sck_s = 1'b1;
			#15;
			if (!ssv) mrx = {mrx[6:0], miso_s};
			sck_s = 1'b0;
			#15;
		end
		mosi_s = ~mosi_s;
	endtask : frame
	task automatic sel(input logic v);
		ss_n = v;
	endtask : sel
endmodule : spiirl_far
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the serial peripheral core with a far-side model.
// Assumes: Strobes and levels change at the falling system clock edge.
// Notes: Rate select 1 gives four-cycle half bits, keeping master bytes short.
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import spiirl_pkg::*;
;
	localparam logic [4:0] K_CTL = 5'h01;
	localparam logic [4:0] K_CFG = 5'h02;
	localparam logic [4:0] K_DWR = 5'h04;
	localparam logic [4:0] K_STR = 5'h08;
	localparam logic [4:0] K_DRD = 5'h10;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic ctl_wr, cfg_wr, st_rd, dat_wr, dat_rd, brk, bce, wait_m, stop_m;
	logic [7:0] wd;
	logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sck_i, ss_n, mosi_i, miso_i;
	logic [7:0] rx_data;
	logic [4:0] ctl_st;
	logic [3:0] cfg_st;
	logic tx_empty, rx_full, ovf, mode_fault_flag, tx_irq, rx_irq, wake, port_act;
	logic sck_w;
	logic miso_w;
	int n_mismatch = 0;
	int total_checks = 0;
	int n_rise = 0;
	int n_fall = 0;
	// Master clock on the wire; pulled low while not driven
	assign sck_w = sck_oe ? sck_o : 1'b0;
	// Slave data line floats up to its pull-up while released
	assign miso_w = miso_oe ? miso_o : 1'b1;
	always @(posedge sck_w) n_rise++;
	always @(negedge sck_w) n_fall++;
	initial forever #10 clk_sys = ~clk_sys;
	spiirl_core i_spiirl_core (.CLK_SYS(clk_sys), .RESET(reset), .SERIAL_CLOCK_IN(sck_i), .SLAVE_SELECT_N(ss_n),
		.MOSI_IN(mosi_i), .MISO_IN(miso_i), .SERIAL_CLOCK_OUT(sck_o), .SERIAL_CLOCK_OE(sck_oe),
		.MOSI_OUT(mosi_o), .MOSI_OE(mosi_oe), .MISO_OUT(miso_o), .MISO_OE(miso_oe), .CONTROL_WRITE(ctl_wr),
		.CONTROL_WDATA(wd[4:0]), .CONFIG_WRITE(cfg_wr), .CONFIG_WDATA(wd[3:0]), .STATUS_READ(st_rd),
		.DATA_WRITE(dat_wr), .DATA_WDATA(wd), .DATA_READ(dat_rd), .BREAK_ACTIVE(brk), .BREAK_CLEAR_ENABLE(bce),
		.WAIT_MODE(wait_m), .STOP_MODE(stop_m), .RX_DATA(rx_data), .CONTROL_STATE(ctl_st), .CONFIG_STATE(cfg_st),
		.TX_EMPTY(tx_empty), .RX_FULL(rx_full), .OVERFLOW(ovf), .MODE_FAULT(mode_fault_flag), .TX_IRQ(tx_irq),
		.RX_ERR_IRQ(rx_irq), .WAKE_REQ(wake), .PORT_ACTIVE(port_act));
	spiirl_far i_spiirl_far (.sck_m(sck_w), .mosi_m(mosi_o), .miso_m(miso_i), .sck_s(sck_i), .ss_n(ss_n),
		.mosi_s(mosi_i), .miso_s(miso_w));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One strobe cycle; returns after the taking edge so results are settled
	task automatic cpu(input logic [4:0] k, input logic [7:0] v);
		@(negedge clk_sys);
		{dat_rd, st_rd, dat_wr, cfg_wr, ctl_wr} = k;
		wd = v;
		@(negedge clk_sys);
		{dat_rd, st_rd, dat_wr, cfg_wr, ctl_wr} = 5'h00;
	endtask : cpu
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	// Bounded waits, long enough for one master byte at the chosen rate
	task automatic wait_fall(input int n);
		for (int i = 0; i < 2000 && n_fall < n; i++) @(negedge clk_sys);
	endtask : wait_fall
	task automatic wait_rx;
		for (int i = 0; i < 300 && rx_full !== 1'b1; i++) @(negedge clk_sys);
	endtask : wait_rx
	task automatic t_reset;
		chk(ctl_st, CTL_RESET);
		chk(cfg_st, CFG_RESET);
		chk({tx_empty, rx_full, ovf, mode_fault_flag, tx_irq, rx_irq, port_act}, 8'h40);
	endtask : t_reset
	// Back-to-back master bytes, overflow, then partial reset by disable
	task automatic t_master;
		cpu(K_CFG, 8'h05);
		cpu(K_CTL, 8'h15);
		chk(tx_irq, 1'b1);
		chk(tx_empty, 1'b1);
		cpu(K_DWR, 8'hA5);
		chk(tx_empty, 1'b0);
		chk(tx_irq, 1'b0);
		chk({sck_oe, mosi_oe}, 8'h03);
		cyc(3);
		chk(tx_empty, 1'b1);
		cpu(K_DWR, 8'h3C);
		chk(tx_empty, 1'b0);
		wait_fall(8);
		cyc(6);
		chk(n_rise[7:0], 8'h09);
		chk(rx_full, 1'b1);
		chk(rx_data, 8'hC0);
		chk(rx_irq, 1'b0);
		chk(tx_empty, 1'b1);
		wait_fall(16);
		cyc(6);
		chk(ovf, 1'b1);
		chk(rx_data, 8'hC0);
		chk(rx_irq, 1'b1);
		chk(i_spiirl_far.got_q[0], 8'hA5);
		chk(i_spiirl_far.got_q[1], 8'h3C);
		cpu(K_CTL, 8'h05);
		chk({tx_empty, port_act}, 8'h02);
		chk(ctl_st, 5'h05);
		chk(cfg_st, 4'h5);
		chk({rx_full, ovf}, 8'h03);
		cpu(K_STR, 8'h00);
		cpu(K_DRD, 8'h00);
		chk({rx_full, ovf, rx_irq}, 8'h00);
		chk({sck_oe, mosi_oe}, 8'h00);
	endtask : t_master
	// Stop freezes a byte mid-way, wait blocks writes but wakes on a request
	task automatic t_lowpower;
		int f;
		cpu(K_CTL, 8'h15);
		cpu(K_DWR, 8'h99);
		wait_fall(20);
		stop_m = 1'b1;
		f = n_fall;
		cyc(40);
		chk(n_fall[7:0], f[7:0]);
		stop_m = 1'b0;
		wait_rx;
		chk(rx_data, 8'hC2);
		chk(i_spiirl_far.got_q[2], 8'h99);
		wait_m = 1'b1;
		cpu(K_CTL, 8'h14);
		chk(ctl_st, 5'h15);
		chk(wake, 1'b1);
		wait_m = 1'b0;
		cpu(K_STR, 8'h00);
		cpu(K_DRD, 8'h00);
	endtask : t_lowpower
	// Master mode fault, clearing around a break with and without clear enable
	task automatic t_fault;
		cpu(K_CFG, 8'h0D);
		i_spiirl_far.sel(1'b0);
		cyc(5);
		chk(mode_fault_flag, 1'b1);
		chk(ctl_st[CTL_ENABLE], 1'b0);
		chk({tx_empty, rx_irq}, 8'h03);
		i_spiirl_far.sel(1'b1);
		cyc(3);
		cpu(K_STR, 8'h00);
		brk = 1'b1;
		cpu(K_CTL, 8'h15);
		chk(mode_fault_flag, 1'b1);
		cpu(K_DWR, 8'h77);
		cyc(20);
		chk(tx_empty, 1'b1);
		chk(n_rise[7:0], 8'h18);
		brk = 1'b0;
		cpu(K_CTL, 8'h15);
		chk(mode_fault_flag, 1'b0);
		i_spiirl_far.sel(1'b0);
		cyc(5);
		chk(mode_fault_flag, 1'b1);
		i_spiirl_far.sel(1'b1);
		cyc(3);
		bce = 1'b1;
		brk = 1'b1;
		cpu(K_STR, 8'h00);
		cpu(K_CTL, 8'h04);
		chk(mode_fault_flag, 1'b0);
		brk = 1'b0;
		bce = 1'b0;
		cyc(2);
		chk(mode_fault_flag, 1'b0);
	endtask : t_fault
	// Slave byte split by a deselect, then a resend with nothing queued
	task automatic t_slave;
		cpu(K_CFG, 8'h00);
		cpu(K_CTL, 8'h12);
		cpu(K_DWR, 8'h5A);
		cyc(4);
		chk(tx_empty, 1'b1);
		#7;
		i_spiirl_far.frame(8'hF0, 4, 1'b0);
		i_spiirl_far.frame(8'h0F, 4, 1'b1);
		cyc(4);
		chk(miso_oe, 1'b0);
		chk({mode_fault_flag, rx_full}, 8'h00);
		#7;
		i_spiirl_far.frame(8'h50, 4, 1'b0);
		wait_rx;
		chk(rx_data, 8'hF5);
		chk(rx_irq, 1'b1);
		chk(i_spiirl_far.mrx, 8'h5A);
		#7;
		i_spiirl_far.frame(8'h33, 8, 1'b0);
		i_spiirl_far.sel(1'b1);
		cyc(6);
		chk(i_spiirl_far.mrx, 8'hF5);
		chk({ovf, rx_full}, 8'h03);
		chk(rx_data, 8'hF5);
	endtask : t_slave
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : final_report
	// Main sequence, with a second reset after traffic
	initial begin
		{ctl_wr, cfg_wr, st_rd, dat_wr, dat_rd, brk, bce, wait_m, stop_m} = 9'h000;
		wd = 8'h00;
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		t_reset;
		t_master;
		t_lowpower;
		t_fault;
		t_slave;
		reset = 1'b1;
		cyc(2);
		reset = 1'b0;
		cyc(1);
		t_reset;
		final_report;
	end
	// Watchdog well beyond the few hundred cycles the sequence needs
	initial begin
		#200000;
		n_mismatch++;
		final_report;
	end
endmodule : tb_top
`default_nettype wire
